//--- src/uhie_pkg.sv
// Package with register map, field positions and bus codes for the host interrupt block.
package uhie_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses.
   // ----------------------------------------------------------------
   localparam logic [7:0] UHIE_OFF_EVENT_FLAGS   = 8'h0c; // Sticky event flags, write one to clear.
   localparam logic [7:0] UHIE_OFF_ENABLE_SET    = 8'h10; // Enable register, write one to set.
   localparam logic [7:0] UHIE_OFF_ENABLE_CLEAR  = 8'h14; // Disable view, write one to clear.
   localparam int         UHIE_ADDR_W            = 8;     // Decoded address width.

   // ----------------------------------------------------------------
   // Field positions shared by flags, enable and disable registers.
   // ----------------------------------------------------------------
   localparam int UHIE_BIT_MASTER      = 31; // Master enable, only in enable and disable views.
   localparam int UHIE_BIT_OWNER       = 30; // Ownership change.
   localparam int UHIE_BIT_ROOT_HUB    = 6;  // Root hub status change.
   localparam int UHIE_BIT_FRAME_OVF   = 5;  // Frame number overflow.
   localparam int UHIE_BIT_RESUME      = 3;  // Resume detected.
   localparam int UHIE_BIT_FRAME_START = 2;  // Start of frame.
   localparam int UHIE_BIT_WRITEBACK   = 1;  // Done-head writeback.
   localparam int UHIE_BIT_OVERRUN     = 0;  // Scheduling overrun.

   // ----------------------------------------------------------------
   // Implemented-bit masks and reset values.
   // ----------------------------------------------------------------
   localparam logic [31:0] UHIE_EVENT_MASK  = 32'h4000_006f; // Event flag bits.
   localparam logic [31:0] UHIE_ENABLE_MASK = 32'hc000_006f; // Enable bits plus master.
   localparam logic [31:0] UHIE_HOST_MASK   = 32'h0000_006f; // Events routed to the host interrupt.
   localparam logic [31:0] UHIE_RESET_VAL   = 32'h0000_0000; // Reset value of every register.

   // ----------------------------------------------------------------
   // AXI4-Lite response codes.
   // ----------------------------------------------------------------
   localparam logic [1:0] UHIE_RESP_OKAY   = 2'h0; // Normal completion.
   localparam logic [1:0] UHIE_RESP_SLVERR = 2'h2; // Unmapped address.

endpackage : uhie_pkg

//--- src/uhie_resume_detect.sv
// Synchroniser and rising-edge detector for the resume signalling pin.
`timescale 1ns/1ns
module uhie_resume_detect (
   input  wire logic clk_i,      // Bus clock.
   input  wire logic rst_n_i,    // Asynchronous reset, active low.
   input  wire logic level_i,    // Asynchronous resume level from the port.
   output logic      rise_o      // One-cycle pulse on a 0 to 1 transition.
);

   // ----------------------------------------------------------------
   // Two-flop synchroniser; only the second stage is looked at.
   // ----------------------------------------------------------------
   logic meta_q;  // First stage, read only by sync_q.
   logic sync_q;  // Second stage, safe to use.
   logic prev_q;  // Previous synchronised value for the edge test.

   // Synchroniser chain and history flop.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= level_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // A steady level never retriggers; only the start of signalling counts.
   assign rise_o = sync_q & ~prev_q;

endmodule // uhie_resume_detect

//--- src/uhie_irq_ctrl.sv
// Event flags, interrupt enables and AXI4-Lite register slave of the host interrupt block.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module uhie_irq_ctrl
   import uhie_pkg::*;
(
   input  wire logic        CLK_I,                  // Bus clock, 125 MHz.
   input  wire logic        RST_N_I,                // Asynchronous reset, active low.
   // AXI4-Lite slave.
   input  wire logic [31:0] S_AXI_AWADDR_I,         // Write address.
   input  wire logic        S_AXI_AWVALID_I,        // Write address valid.
   output logic             S_AXI_AWREADY_O,        // Write address ready.
   input  wire logic [31:0] S_AXI_WDATA_I,          // Write data.
   input  wire logic [3:0]  S_AXI_WSTRB_I,          // Write byte strobes.
   input  wire logic        S_AXI_WVALID_I,         // Write data valid.
   output logic             S_AXI_WREADY_O,         // Write data ready.
   output logic [1:0]       S_AXI_BRESP_O,          // Write response.
   output logic             S_AXI_BVALID_O,         // Write response valid.
   input  wire logic        S_AXI_BREADY_I,         // Write response ready.
   input  wire logic [31:0] S_AXI_ARADDR_I,         // Read address.
   input  wire logic        S_AXI_ARVALID_I,        // Read address valid.
   output logic             S_AXI_ARREADY_O,        // Read address ready.
   output logic [31:0]      S_AXI_RDATA_O,          // Read data.
   output logic [1:0]       S_AXI_RRESP_O,          // Read response.
   output logic             S_AXI_RVALID_O,         // Read data valid.
   input  wire logic        S_AXI_RREADY_I,         // Read data ready.
   // Event sources from the rest of the controller, same clock except RESUME_SIGNAL_I, which is asynchronous.
   input  wire logic        OWNER_CHANGE_REQ_I,     // Ownership change request bit of the command register.
   input  wire logic        ROOT_HUB_CHANGE_I,      // Pulse: root hub or port status changed.
   input  wire logic        FRAME_NUM_MSB_I,        // Bit 15 of the frame number.
   input  wire logic        FRAME_NUM_UPDATED_I,    // Pulse: shared area frame number written.
   input  wire logic        FRAME_START_I,          // Pulse: frame start after frame number update.
   input  wire logic        DONE_HEAD_WRITTEN_I,    // Pulse: done head written to shared area.
   input  wire logic        SCHED_OVERRUN_I,        // Pulse: schedule overran, after frame update.
   input  wire logic        SW_RESUME_STATE_I,      // High while software holds the resume state.
   input  wire logic        RESUME_SIGNAL_I,        // Asynchronous resume signalling from a device.
   // Outputs.
   output logic             IRQ_O,                  // Host bus interrupt level, active high.
   output logic             SYS_MGMT_IRQ_OUT_N_O,   // System management interrupt, active low.
   output logic             SOF_TOKEN_O,            // Pulse: send start-of-frame token.
   output logic             OVERRUN_COUNT_INC_O,    // Pulse: bump the overrun counter.
   output logic             DONE_WRITEBACK_ALLOW_O  // High while a new done-head writeback may happen.
);

   // ----------------------------------------------------------------
   // Helper functions.
   // ----------------------------------------------------------------

   // Keep only the written bytes of a word, so unstrobed lanes act as zeros.
   function automatic logic [31:0] strb_mask(input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return data & m;
   endfunction

   // True when an address hits one of the three mapped words.
   function automatic logic addr_hit(input logic [UHIE_ADDR_W-1:0] a);
      return (a == UHIE_OFF_EVENT_FLAGS) || (a == UHIE_OFF_ENABLE_SET) || (a == UHIE_OFF_ENABLE_CLEAR);
   endfunction

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   logic [31:0]            flags_q;      // Sticky event flags.
   logic [31:0]            flags_d;      // Next flags.
   logic [31:0]            en_q;         // Enable bits plus master.
   logic [31:0]            en_d;         // Next enables.
   logic                   own_req_q;    // Previous ownership request, for the edge.
   logic                   msb_seen_q;   // Frame MSB at the last shared-area update.
   logic                   resume_rise;  // Synchronised resume start pulse.
   logic [31:0]            set_vec;      // Hardware set requests this cycle.
   // Write channel holding registers.
   logic                   aw_held_q;    // Write address taken and waiting.
   logic                   w_held_q;     // Write data taken and waiting.
   logic [UHIE_ADDR_W-1:0] waddr_q;      // Held write address.
   logic [31:0]            wdata_q;      // Held write data, strobes applied.
   logic                   bvalid_q;     // Write response pending.
   logic [1:0]             bresp_q;      // Write response code.
   logic                   wr_go;        // Perform the held write this cycle.
   logic [31:0]            clr_vec;      // Software clear of flags this cycle.
   // Read channel.
   logic                   rvalid_q;     // Read data pending.
   logic [31:0]            rdata_q;      // Read data.
   logic [1:0]             rresp_q;      // Read response code.
   logic [UHIE_ADDR_W-1:0] raddr;        // Decoded read address.

   // ----------------------------------------------------------------
   // Resume detection through the synchroniser.
   // ----------------------------------------------------------------
   uhie_resume_detect u_resume (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .level_i (RESUME_SIGNAL_I),
      .rise_o  (resume_rise)
   );

   // ----------------------------------------------------------------
   // Event history flops.
   // ----------------------------------------------------------------

   // Past request level and frame MSB at the last shared-area update.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         own_req_q  <= 1'b0;
         msb_seen_q <= 1'b0;
      end else begin
         own_req_q <= OWNER_CHANGE_REQ_I;
         if (FRAME_NUM_UPDATED_I) begin
            msb_seen_q <= FRAME_NUM_MSB_I;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event set vector.
   // ----------------------------------------------------------------

   // Each source sets its own flag position; the rest stay zero.
   always_comb begin
      set_vec = UHIE_RESET_VAL;
      set_vec[UHIE_BIT_OWNER]       = OWNER_CHANGE_REQ_I & ~own_req_q;
      set_vec[UHIE_BIT_ROOT_HUB]    = ROOT_HUB_CHANGE_I;
      // The toggle is judged at the shared-area update, so the flag follows it.
      set_vec[UHIE_BIT_FRAME_OVF]   = FRAME_NUM_UPDATED_I & (FRAME_NUM_MSB_I ^ msb_seen_q);
      // Software-driven resume shows no device signalling, so it is filtered out.
      set_vec[UHIE_BIT_RESUME]      = resume_rise & ~SW_RESUME_STATE_I;
      set_vec[UHIE_BIT_FRAME_START] = FRAME_START_I;
      set_vec[UHIE_BIT_WRITEBACK]   = DONE_HEAD_WRITTEN_I;
      set_vec[UHIE_BIT_OVERRUN]     = SCHED_OVERRUN_I;
   end

   // ----------------------------------------------------------------
   // Register updates.
   // ----------------------------------------------------------------

   // Software clear of flags comes only from a write of ones to the flag word.
   assign wr_go   = aw_held_q & w_held_q & ~bvalid_q;
   assign clr_vec = (wr_go && waddr_q == UHIE_OFF_EVENT_FLAGS) ? wdata_q : UHIE_RESET_VAL;

   // A set arriving together with its clear wins, so no event is lost.
   always_comb begin
      flags_d = ((flags_q & ~clr_vec) | set_vec) & UHIE_EVENT_MASK;
      en_d    = en_q;
      if (wr_go && waddr_q == UHIE_OFF_ENABLE_SET) begin
         en_d = en_q | (wdata_q & UHIE_ENABLE_MASK);
      end else if (wr_go && waddr_q == UHIE_OFF_ENABLE_CLEAR) begin
         en_d = en_q & ~(wdata_q & UHIE_ENABLE_MASK);
      end
   end

   // Flags and enables; both start cleared so nothing can interrupt early.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         flags_q <= UHIE_RESET_VAL;
         en_q    <= UHIE_RESET_VAL;
      end else begin
         flags_q <= flags_d;
         en_q    <= en_d;
      end
   end

   // Token and counter pulses leave on the same edge that sets their flags.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SOF_TOKEN_O         <= 1'b0;
         OVERRUN_COUNT_INC_O <= 1'b0;
      end else begin
         SOF_TOKEN_O         <= FRAME_START_I;
         OVERRUN_COUNT_INC_O <= SCHED_OVERRUN_I;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt outputs.
   // ----------------------------------------------------------------

   // Ownership change goes only to the management line, never to the host line.
   assign IRQ_O = en_q[UHIE_BIT_MASTER] & (|(flags_q & en_q & UHIE_HOST_MASK));
   assign SYS_MGMT_IRQ_OUT_N_O = ~(flags_q[UHIE_BIT_OWNER] & en_q[UHIE_BIT_OWNER]);
   // The writeback source must hold off while the flag stands.
   assign DONE_WRITEBACK_ALLOW_O = ~flags_q[UHIE_BIT_WRITEBACK];

   // ----------------------------------------------------------------
   // AXI4-Lite write channel.
   // ----------------------------------------------------------------

   // Address and data are taken independently; the write happens once both are in.
   assign S_AXI_AWREADY_O = ~aw_held_q & ~bvalid_q;
   assign S_AXI_WREADY_O  = ~w_held_q & ~bvalid_q;
   assign S_AXI_BVALID_O  = bvalid_q;
   assign S_AXI_BRESP_O   = bresp_q;

   // Holding registers and the response.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         waddr_q   <= '0;
         wdata_q   <= UHIE_RESET_VAL;
         bvalid_q  <= 1'b0;
         bresp_q   <= UHIE_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held_q <= 1'b1;
            waddr_q   <= S_AXI_AWADDR_I[UHIE_ADDR_W-1:0];
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held_q <= 1'b1;
            wdata_q  <= strb_mask(S_AXI_WDATA_I, S_AXI_WSTRB_I);
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= addr_hit(waddr_q) ? UHIE_RESP_OKAY : UHIE_RESP_SLVERR;
         end else if (bvalid_q && S_AXI_BREADY_I) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel.
   // ----------------------------------------------------------------
   assign S_AXI_ARREADY_O = ~rvalid_q;
   assign S_AXI_RVALID_O  = rvalid_q;
   assign S_AXI_RDATA_O   = rdata_q;
   assign S_AXI_RRESP_O   = rresp_q;
   assign raddr           = S_AXI_ARADDR_I[UHIE_ADDR_W-1:0];

   // Data is captured at the address handshake; reads have no side effects.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rvalid_q <= 1'b0;
         rdata_q  <= UHIE_RESET_VAL;
         rresp_q  <= UHIE_RESP_OKAY;
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         rvalid_q <= 1'b1;
         rresp_q  <= addr_hit(raddr) ? UHIE_RESP_OKAY : UHIE_RESP_SLVERR;
         if (raddr == UHIE_OFF_EVENT_FLAGS) begin
            rdata_q <= flags_q;
         end else if (raddr == UHIE_OFF_ENABLE_SET || raddr == UHIE_OFF_ENABLE_CLEAR) begin
            rdata_q <= en_q;
         end else begin
            rdata_q <= UHIE_RESET_VAL;
         end
      end else if (rvalid_q && S_AXI_RREADY_I) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_owner_flag_set: assert property (
      (OWNER_CHANGE_REQ_I && !own_req_q) |=> flags_q[UHIE_BIT_OWNER])
      else $error("Ownership request did not set its flag.");

   a_mgmt_irq_tie: assert property (
      (flags_q[UHIE_BIT_OWNER] && en_q[UHIE_BIT_OWNER]) |->
         (!SYS_MGMT_IRQ_OUT_N_O && !($rose(IRQ_O) && !(|(flags_q & en_q & UHIE_HOST_MASK)))))
      else $error("Management interrupt not asserted for ownership change.");

   a_mgmt_irq_idle: assert property (
      !(flags_q[UHIE_BIT_OWNER] && en_q[UHIE_BIT_OWNER]) |-> SYS_MGMT_IRQ_OUT_N_O)
      else $error("Management interrupt asserted without an enabled ownership change.");

   a_root_hub_set: assert property (
      ROOT_HUB_CHANGE_I |=> flags_q[UHIE_BIT_ROOT_HUB])
      else $error("Root hub change did not set its flag.");

   a_frame_ovf_set: assert property (
      (FRAME_NUM_UPDATED_I && (FRAME_NUM_MSB_I != msb_seen_q)) |=> flags_q[UHIE_BIT_FRAME_OVF])
      else $error("Frame overflow flag missed.");

   a_frame_ovf_only: assert property (
      ($rose(flags_q[UHIE_BIT_FRAME_OVF])) |-> $past(FRAME_NUM_UPDATED_I))
      else $error("Frame overflow flag set without a frame update.");

   a_resume_sw_quiet: assert property (
      (!flags_q[UHIE_BIT_RESUME] && (SW_RESUME_STATE_I || !resume_rise)) |=> !flags_q[UHIE_BIT_RESUME])
      else $error("Resume flag set without device signalling.");

   a_sof_with_flag: assert property (
      FRAME_START_I |=> (SOF_TOKEN_O && flags_q[UHIE_BIT_FRAME_START]))
      else $error("Token and frame start flag not together.");

   a_writeback_hold: assert property (
      DONE_HEAD_WRITTEN_I |=> (flags_q[UHIE_BIT_WRITEBACK] && !DONE_WRITEBACK_ALLOW_O))
      else $error("Writeback flag did not block further writebacks.");

   a_writeback_allow: assert property (
      !flags_q[UHIE_BIT_WRITEBACK] |-> DONE_WRITEBACK_ALLOW_O)
      else $error("Writeback held off while its flag is clear.");

   a_overrun_count: assert property (
      SCHED_OVERRUN_I |=> (OVERRUN_COUNT_INC_O && flags_q[UHIE_BIT_OVERRUN]))
      else $error("Overrun did not set flag and bump counter.");

   a_host_irq_level: assert property (
      IRQ_O == (en_q[UHIE_BIT_MASTER] && ((flags_q & en_q & UHIE_HOST_MASK) != UHIE_RESET_VAL)))
      else $error("Host interrupt level wrong.");

   a_enable_hold: assert property (
      !wr_go |=> $stable(en_q))
      else $error("Enable bits changed without a write.");

   a_reserved_zero: assert property (
      ((en_q & ~UHIE_ENABLE_MASK) == UHIE_RESET_VAL) && ((flags_q & ~UHIE_EVENT_MASK) == UHIE_RESET_VAL))
      else $error("Reserved bit became set.");

   a_flag_sticky: assert property (
      ((flags_q & ~flags_d) != UHIE_RESET_VAL) |-> (wr_go && waddr_q == UHIE_OFF_EVENT_FLAGS))
      else $error("Flag cleared without a software write.");

   a_write_answer: assert property (
      wr_go |=> (bvalid_q [*1]) ##0 !aw_held_q)
      else $error("Write response did not follow the write.");

   c_host_irq: cover property ($rose(IRQ_O));
   c_mgmt_irq: cover property ($fell(SYS_MGMT_IRQ_OUT_N_O));
   c_set_and_clear: cover property (wr_go && (clr_vec & set_vec) != UHIE_RESET_VAL);
   c_read_back: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);

endmodule // uhie_irq_ctrl

//--- bench/uhie_host_model.sv
// Host driver model: an AXI4-Lite master that runs one access at a time.
`timescale 1ns/1ns
module uhie_host_model (
   input  wire logic        clk_i,  // Bus clock.
   input  wire logic        awr_i,  // Write address ready.
   input  wire logic        wr_i,   // Write data ready.
   input  wire logic        bv_i,   // Write response valid.
   input  wire logic [1:0]  br_i,   // Write response code.
   input  wire logic        arr_i,  // Read address ready.
   input  wire logic        rv_i,   // Read data valid.
   input  wire logic [31:0] rd_i,   // Read data.
   input  wire logic [1:0]  rr_i    // Read response code.
);
   logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0; // Channel handshakes.
   logic [31:0] aa = 0, wd = 0;                             // Address and write data.
   logic        tmo = 0;                                    // Set if an answer never came.

   // ----------------------------------------------------------------
   // Each handshake is judged at the rising edge that completes it, from
   // the values that stood before that edge; requests change just after it.
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'h3;
      @(posedge clk_i);
      aa <= {24'h0, a};
      wd <= d;
      {awv, wv, bry} <= 3'h7;
      repeat (64) begin
         @(posedge clk_i);
         if (awv && awr_i) awv <= 0;
         if (wv && wr_i) wv <= 0;
         if (bv_i) begin r = br_i; bry <= 0; return; end
      end
      tmo = 1;
   endtask

   // A read holds the address until taken and rready until the data come.
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {d, r} = '1;
      @(posedge clk_i);
      aa <= {24'h0, a};
      {arv, rry} <= 2'h3;
      repeat (64) begin
         @(posedge clk_i);
         if (arv && arr_i) arv <= 0;
         if (rv_i) begin d = rd_i; r = rr_i; rry <= 0; return; end
      end
      tmo = 1;
   endtask
endmodule // uhie_host_model

//--- bench/testbench.sv
// Self-checking testbench for the host interrupt block.
`timescale 1ns/1ns
module testbench;
   import uhie_pkg::*;
   logic        clk, rst_n, own, msb, swr, res; // Clock, reset and event levels.
   logic [4:0]  ev;                             // Pulses: hub, update, sof, head, overrun.
   logic        awr, wrdy, bv, arr, rv, irq, sys_mgmt_irq_out, sof, inc, wb_ok;
   logic [1:0]  br, rr;                         // Response codes.
   logic [31:0] rdat;                           // Read data.
   logic [3:0]  strb;                           // Write byte strobes.
   int          errors, n_compared;

   uhie_host_model host (.clk_i(clk), .awr_i(awr), .wr_i(wrdy), .bv_i(bv), .br_i(br),
      .arr_i(arr), .rv_i(rv), .rd_i(rdat), .rr_i(rr));
   uhie_irq_ctrl uut (.CLK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWADDR_I(host.aa), .S_AXI_AWVALID_I(host.awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(host.wd), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(host.wv),
      .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(host.bry),
      .S_AXI_ARADDR_I(host.aa), .S_AXI_ARVALID_I(host.arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(host.rry),
      .OWNER_CHANGE_REQ_I(own), .ROOT_HUB_CHANGE_I(ev[4]), .FRAME_NUM_MSB_I(msb),
      .FRAME_NUM_UPDATED_I(ev[3]), .FRAME_START_I(ev[2]), .DONE_HEAD_WRITTEN_I(ev[1]),
      .SCHED_OVERRUN_I(ev[0]), .SW_RESUME_STATE_I(swr), .RESUME_SIGNAL_I(res),
      .IRQ_O(irq), .SYS_MGMT_IRQ_OUT_N_O(sys_mgmt_irq_out), .SOF_TOKEN_O(sof),
      .OVERRUN_COUNT_INC_O(inc), .DONE_WRITEBACK_ALLOW_O(wb_ok));

   // ----------------------------------------------------------------
   // Shared helpers: compare, bus accesses, event pulses, verdict.
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // A hung bus counts as a mismatch and ends the run at once.
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = UHIE_RESP_OKAY);
      logic [1:0] r;
      host.wr(a, d, r);
      if (host.tmo) begin errors++; test_done; end
      chk(r, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = UHIE_RESP_OKAY);
      logic [31:0] d;
      logic [1:0]  r;
      host.rd(a, d, r);
      if (host.tmo) begin errors++; test_done; end
      chk(d, e);
      chk(r, er);
   endtask
   // One-cycle pulse; returns the token and counter strobes just after it is taken.
   task automatic pulse(input logic [4:0] m, output logic [1:0] so);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 0;
      #1 so = {sof, inc};
   endtask

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task t_regs;
      rdc(8'h10, 32'h0);
      rdc(8'h14, 32'h0);
      strb <= 4'h1;
      wrc(8'h10, 32'hffff_ffff);
      strb <= 4'hf;
      rdc(8'h10, 32'h0000_006f);
      wrc(8'h10, 32'hffff_ffff);
      rdc(8'h10, 32'hc000_006f);
      wrc(8'h10, 32'h0);
      rdc(8'h10, 32'hc000_006f);
      wrc(8'h14, 32'h8000_0021);
      rdc(8'h14, 32'h4000_004e);
      rdc(8'h10, 32'h4000_004e);
      wrc(8'h40, 32'h1, UHIE_RESP_SLVERR);
      rdc(8'h40, 32'h0, UHIE_RESP_SLVERR);
   endtask
   task automatic t_events;
      logic [4:0]  pm [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
      logic [31:0] pf [4] = '{32'h40, 32'h04, 32'h02, 32'h01};
      logic [1:0]  ps [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
      logic [31:0] acc;
      logic [1:0]  so;
      acc = 0;
      wrc(8'h10, 32'hffff_ffff);
      for (int i = 0; i < 4; i++) begin
         pulse(pm[i], so);
         acc |= pf[i];
         chk(so, ps[i]);
         chk(irq, 1);
         rdc(8'h0c, acc);
      end
      chk(wb_ok, 0);
      wrc(8'h0c, 32'h0);
      rdc(8'h0c, acc);
      wrc(8'h0c, 32'h2);
      rdc(8'h0c, acc & ~32'h2);
      chk(wb_ok, 1);
      wrc(8'h14, 32'h8000_0000);
      chk(irq, 0);
      wrc(8'h10, 32'h8000_0000);
      chk(irq, 1);
      wrc(8'h0c, 32'hffff_ffff);
      chk(irq, 0);
      rdc(8'h0c, 32'h0);
   endtask
   task t_owner;
      @(posedge clk) own <= 1;
      rdc(8'h0c, 32'h4000_0000);
      chk(sys_mgmt_irq_out, 0);
      chk(irq, 0);
      wrc(8'h14, 32'h4000_0000);
      chk(sys_mgmt_irq_out, 1);
      wrc(8'h0c, 32'h4000_0000);
      own <= 0;
   endtask
   // Overflow is judged on each update against the bit seen at the last one.
   task automatic t_ovf;
      logic [1:0] so;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) msb <= (i < 2);
         pulse(5'h08, so);
         rdc(8'h0c, (i == 1) ? 32'h0 : 32'h20);
         wrc(8'h0c, 32'h20);
      end
   endtask
   // A rise while software holds the resume state must be ignored.
   task t_res;
      @(posedge clk) {swr, res} <= 2'h3;
      repeat (8) @(posedge clk);
      rdc(8'h0c, 32'h0);
      @(posedge clk) {swr, res} <= 2'h0;
      repeat (8) @(posedge clk);
      res <= 1;
      repeat (8) @(posedge clk);
      rdc(8'h0c, 32'h8);
      chk(irq, 1);
   endtask

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial begin
      {rst_n, own, msb, swr, res, ev, errors, n_compared} = 0;
      strb = 4'hf;
      repeat (20) @(posedge clk);
      rst_n <= 1;
      #1 chk({irq, sys_mgmt_irq_out, wb_ok}, 3'h3);
      t_regs;
      t_events;
      t_owner;
      t_ovf;
      t_res;
      test_done;
   end
endmodule // testbench
